// >>> design/pscfg_ctrl.sv
// pSRAM configuration sequence, write capture, standby and power-down reset
//
// Contract
// - Async: done after page time (to async) or read time (to sync).
// - Sync: done after the configuration recovery time following cycle six.
// - Synchronous writes capture data on every clock edge with write enable low, address valid high and configuration not busy.
// - Early OE/WE release at select rise delays standby by the read cycle count plus one clock.
// - Power enable low then high acts as a device reset.
`timescale 1ns/1ps
module pscfg_ctrl
   import pscfg_pkg::*;
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // Memory bus pins
   input  wire pscfg_bus_t        bus,
   // Captured writes
   output pscfg_wr_t              wr_r,
   // Mode and status
   output logic                   sync_mode_r,
   output logic [DATA_W-1:0]      cfg_key_r,
   output logic                   cfg_busy_r,
   output logic                   wait_n_r,
   output logic                   standby_r,
   output logic                   powered_down_r
);

   // ------------------------------------------------------------
   // Pin history
   // ------------------------------------------------------------
   logic              cs_n_prev_r;
   logic              oe_n_prev_r;
   logic              we_n_prev_r;
   logic              pwr_prev_r;
   logic [ADDR_W-1:0] addr_lat_r;
   logic              be_seen_r;
   pscfg_state_t      cfg_state_r;

   logic cs_rise;
   logic cs_active;
   logic pd_hold;
   logic pwr_rise;

   assign cs_active = !bus.chip_select_n && bus.power_enable;
   assign cs_rise   = !cs_n_prev_r && bus.chip_select_n;
   assign pd_hold   = !bus.power_enable;
   assign pwr_rise  = !pwr_prev_r && bus.power_enable;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cs_n_prev_r <= 1'b1;
         oe_n_prev_r <= 1'b1;
         we_n_prev_r <= 1'b1;
         pwr_prev_r  <= 1'b0;
      end else begin
         cs_n_prev_r <= bus.chip_select_n;
         oe_n_prev_r <= bus.output_enable_n;
         we_n_prev_r <= bus.write_enable_n;
         pwr_prev_r  <= bus.power_enable;
      end
   end

   // ------------------------------------------------------------
   // Address latch and per-access observations
   // ------------------------------------------------------------
   // Address taken on each edge with select active and address valid low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addr_lat_r <= '0;
      end else if (cs_active && !bus.address_valid_n) begin
         addr_lat_r <= bus.addr;
      end else if (cs_active && sync_mode_r && !bus.write_enable_n
                   && cfg_state_r == PSCFG_NORMAL) begin
         addr_lat_r <= addr_lat_r + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         be_seen_r <= 1'b0;
      end else if (!cs_active) begin
         be_seen_r <= 1'b0;
      end else begin
         // A cycle with neither byte enable low does not count
         if (!bus.low_byte_enable_n || !bus.high_byte_enable_n) begin
            be_seen_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Configuration sequence
   // ------------------------------------------------------------
   logic [2:0]   seq_cnt_r;
   logic         tmr_load;
   logic [TMR_W-1:0] tmr_count;
   logic         tmr_busy;
   logic         tmr_done;
   logic         addr_ones;
   logic         key_sync;

   assign addr_ones = &addr_lat_r;
   assign key_sync  = addr_lat_r[KEY_SYNC_BIT];

   // Sixth access: timer picks the recovery interval for the mode
   assign tmr_load = cs_rise && cfg_state_r == PSCFG_COLLECT
                     && seq_cnt_r == SEQ_KEY_CYCLES && be_seen_r;
   always_comb begin
      if (sync_mode_r) begin
         tmr_count = RECOV_CYC;
      end else if (key_sync) begin
         tmr_count = READ_CYC;
      end else begin
         tmr_count = PAGE_CYC;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_state_r <= PSCFG_NORMAL;
         seq_cnt_r   <= 3'h0;
      end else if (pd_hold) begin
         cfg_state_r <= PSCFG_NORMAL;
         seq_cnt_r   <= 3'h0;
      end else begin
         unique case (cfg_state_r)
            PSCFG_NORMAL: begin
               if (cs_rise && addr_ones && be_seen_r) begin
                  cfg_state_r <= PSCFG_COLLECT;
                  seq_cnt_r   <= 3'h1;
               end
            end
            PSCFG_COLLECT: begin
               if (tmr_load) begin
                  cfg_state_r <= PSCFG_RECOVER;
                  seq_cnt_r   <= 3'h0;
               end else if (cs_rise) begin
                  if (!be_seen_r) begin
                     seq_cnt_r <= seq_cnt_r;
                  end else if (addr_ones) begin
                     seq_cnt_r <= seq_cnt_r + 3'h1;
                  end else begin
                     // Stray address drops back to plain accesses
                     cfg_state_r <= PSCFG_NORMAL;
                     seq_cnt_r   <= 3'h0;
                  end
               end
            end
            PSCFG_RECOVER: begin
               if (tmr_done) begin
                  cfg_state_r <= PSCFG_NORMAL;
               end
            end
            default: begin
               cfg_state_r <= PSCFG_NORMAL;
               seq_cnt_r   <= 3'h0;
            end
         endcase
      end
   end

   pscfg_timer u_cfg_timer (
      .clock  (clock),
      .rst_n  (rst_n),
      .clear  (pd_hold),
      .load   (tmr_load),
      .count  (tmr_count),
      .busy_r (tmr_busy),
      .done_r (tmr_done)
   );

   // Key bits beyond the mode bit are kept but not decoded
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_mode_r <= 1'b0;
         cfg_key_r   <= KEY_RESET;
      end else if (pd_hold) begin
         sync_mode_r <= 1'b0;
         cfg_key_r   <= KEY_RESET;
      end else if (tmr_load) begin
         sync_mode_r <= key_sync;
         cfg_key_r   <= addr_lat_r[DATA_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_busy_r <= 1'b0;
         wait_n_r   <= 1'b1;
      end else begin
         cfg_busy_r <= tmr_load || (tmr_busy && !tmr_done);
         wait_n_r   <= !(tmr_load || (tmr_busy && !tmr_done));
      end
   end

   // ------------------------------------------------------------
   // Write capture
   // ------------------------------------------------------------
   logic sync_wr;
   logic async_wr;

   // Sync: every edge with write enable low, address valid high and configuration not busy; clock runs under select
   assign sync_wr  = cs_active && sync_mode_r && !bus.write_enable_n
                     && bus.address_valid_n && !cfg_busy_r;
   // Async: data taken at the closing edge of write enable or select
   assign async_wr = !sync_mode_r && !we_n_prev_r && !cs_n_prev_r
                     && (bus.write_enable_n || bus.chip_select_n)
                     && !cfg_busy_r && bus.power_enable;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_r <= '0;
      end else if (sync_wr || async_wr) begin
         wr_r.valid   <= 1'b1;
         wr_r.addr    <= addr_lat_r;
         wr_r.data    <= bus.data;
         wr_r.byte_en <= {!bus.high_byte_enable_n,
                          !bus.low_byte_enable_n};
      end else begin
         wr_r.valid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Standby entry
   // ------------------------------------------------------------
   logic sb_early;
   logic sb_done;

   // Release on the same edge as select rise beats the hold margin
   assign sb_early = cs_rise && bus.power_enable
                     && ((!oe_n_prev_r && bus.output_enable_n)
                      || (!we_n_prev_r && bus.write_enable_n));

   pscfg_timer u_sb_timer (
      .clock  (clock),
      .rst_n  (rst_n),
      .clear  (!bus.chip_select_n || pd_hold),
      .load   (sb_early),
      .count  (READ_CYC),
      .busy_r (),
      .done_r (sb_done)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         standby_r <= 1'b1;
      end else if (!bus.chip_select_n || pd_hold) begin
         standby_r <= 1'b0;
      end else if (sb_done) begin
         standby_r <= 1'b1;
      end else if (cs_rise && !sb_early) begin
         standby_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Power-down
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         powered_down_r <= 1'b0;
      end else if (pd_hold) begin
         powered_down_r <= 1'b1;
      end else if (pwr_rise) begin
         powered_down_r <= 1'b0;
      end
   end

endmodule

// >>> design/pscfg_pkg.sv
// Shared constants and carrier types for the pSRAM configuration control
package pscfg_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int TMR_W  = 8;

   // ------------------------------------------------------------
   // Timing, in ns, and derived cycle counts at the 10 MHz clock
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS           = 100;
   localparam int PAGE_CYCLE_TIME_NS      = 20;
   localparam int READ_CYCLE_TIME_NS      = 70;
   localparam int CONFIG_RECOVERY_TIME_NS = 40;
   localparam int SELECT_HIGH_TO_OE_RELEASE_NS = 10;

   // Least times round up, never below one cycle
   localparam int PAGE_CYC_I = (PAGE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int READ_CYC_I = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int RECOV_CYC_I = (CONFIG_RECOVERY_TIME_NS
                                 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [TMR_W-1:0] PAGE_CYC  =
      TMR_W'((PAGE_CYC_I < 1) ? 1 : PAGE_CYC_I);
   localparam logic [TMR_W-1:0] READ_CYC  =
      TMR_W'((READ_CYC_I < 1) ? 1 : READ_CYC_I);
   localparam logic [TMR_W-1:0] RECOV_CYC =
      TMR_W'((RECOV_CYC_I < 1) ? 1 : RECOV_CYC_I);

   // ------------------------------------------------------------
   // Configuration sequence
   // ------------------------------------------------------------
   localparam logic [2:0] SEQ_KEY_CYCLES = 3'h5;
   localparam int         KEY_SYNC_BIT   = 15;
   localparam logic [DATA_W-1:0] KEY_RESET = 16'h0000;

   typedef enum logic [1:0] {
      PSCFG_NORMAL  = 2'b00,
      PSCFG_COLLECT = 2'b01,
      PSCFG_RECOVER = 2'b11
   } pscfg_state_t;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic              chip_select_n;
      logic              power_enable;
      logic              address_valid_n;
      logic              output_enable_n;
      logic              write_enable_n;
      logic              low_byte_enable_n;
      logic              high_byte_enable_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pscfg_bus_t;

   typedef struct packed {
      logic              valid;
      logic [1:0]        byte_en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pscfg_wr_t;

endpackage

// >>> design/pscfg_timer.sv
// Down-counting interval timer with a registered busy flag
`timescale 1ns/1ps
module pscfg_timer
   import pscfg_pkg::*;
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Control
   input  wire logic             clear,
   input  wire logic             load,
   input  wire logic [TMR_W-1:0] count,
   // Status
   output logic                  busy_r,
   output logic                  done_r
);

   logic [TMR_W-1:0] cnt_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else if (clear) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else if (load) begin
         cnt_r  <= count;
         busy_r <= 1'b1;
         done_r <= 1'b0;
      end else if (cnt_r != '0) begin
         cnt_r  <= cnt_r - 1'b1;
         busy_r <= (cnt_r != 1'b1);
         done_r <= (cnt_r == 1'b1);
      end else begin
         done_r <= 1'b0;
      end
   end

endmodule

// >>> verif/pscfg_ctrl_bench.sv
// Self-checking bench for the pSRAM configuration control
`timescale 1ns/1ps
module pscfg_ctrl_bench;
   import pscfg_pkg::*;
   logic              clock;
   logic              rst_n;
   pscfg_bus_t        bus;
   pscfg_wr_t         wr_r;
   logic              sync_mode_r;
   logic [DATA_W-1:0] cfg_key_r;
   logic              cfg_busy_r;
   logic              wait_n_r;
   logic              standby_r;
   logic              powered_down_r;
   int                fails = 0;
   int                checked = 0;
   int                cycles = 0;

   pscfg_ctrl u_pscfg_ctrl (.clock(clock), .rst_n(rst_n), .bus(bus),
      .wr_r(wr_r), .sync_mode_r(sync_mode_r), .cfg_key_r(cfg_key_r),
      .cfg_busy_r(cfg_busy_r), .wait_n_r(wait_n_r), .standby_r(standby_r),
      .powered_down_r(powered_down_r));
   pscfg_host_model u_pscfg_host_model (.clock(clock), .bus(bus));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick;
      @(posedge clock);
      #10;
   endtask

   // Busy cycles seen over a window wider than any recovery
   task automatic busy_len(output int n, output int w);
      n = 0;
      w = 0;
      repeat (4) begin
         tick();
         if (cfg_busy_r === 1'b1)
            n++;
         if (wait_n_r === 1'b0)
            w++;
      end
   endtask

   task automatic stby_wait(output int n);
      n = 0;
      while (standby_r !== 1'b1 && n < 10) begin
         tick();
         n++;
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_cfg(input logic [ADDR_W-1:0] key6,
                        input int exp_len, input logic exp_sync);
      int n;
      int w;
      for (int i = 0; i < 6; i++)
         u_pscfg_host_model.cfg_access(i == 5 ? key6 : '1, 2'(i % 3));
      busy_len(n, w);
      // Busy flag is a register behind the interval timer: one extra cycle
      chk(n, exp_len + 1);
      chk(w, exp_len + 1);
      chk(sync_mode_r, exp_sync);
      chk(cfg_key_r, key6[15:0]);
      $display("config sequence test done");
   endtask

   task automatic t_abandon;
      int n;
      int w;
      repeat (3) u_pscfg_host_model.cfg_access('1, 2'b10);
      u_pscfg_host_model.cfg_access(22'h3ffffe, 2'b01);
      repeat (2) u_pscfg_host_model.cfg_access('1, 2'b00);
      u_pscfg_host_model.cfg_access(22'h008000, 2'b10);
      busy_len(n, w);
      chk(n, 0);
      chk(w, 0);
      chk(sync_mode_r, 1'b0);
      $display("abandon test done");
   endtask

   task automatic t_sync_write;
      u_pscfg_host_model.drive(0, 0, 1, 1, 2'b11, 22'h000123, 16'h0000);
      u_pscfg_host_model.drive(0, 1, 1, 0, 2'b10, 22'h000000, 16'ha5a5);
      u_pscfg_host_model.drive(0, 1, 1, 0, 2'b00, 22'h000000, 16'h5a5a);
      chk({wr_r.valid, wr_r.byte_en, wr_r.addr}, {3'h5, 22'h000123});
      chk(wr_r.data, 16'ha5a5);
      u_pscfg_host_model.drive(1, 1, 1, 1, 2'b11, 22'h000000, 16'h0000);
      chk({wr_r.valid, wr_r.byte_en, wr_r.addr}, {3'h7, 22'h000124});
      chk(wr_r.data, 16'h5a5a);
      $display("sync write test done");
   endtask

   task automatic t_standby;
      int n0;
      int n1;
      u_pscfg_host_model.drive(0, 0, 1, 1, 2'b10, 22'h000010, 16'h0000);
      u_pscfg_host_model.drive(0, 1, 1, 1, 2'b10, 22'h000010, 16'h0000);
      u_pscfg_host_model.drive(1, 1, 1, 1, 2'b11, 22'h000010, 16'h0000);
      stby_wait(n0);
      u_pscfg_host_model.drive(0, 0, 0, 1, 2'b10, 22'h000020, 16'h0000);
      u_pscfg_host_model.drive(0, 1, 0, 1, 2'b10, 22'h000020, 16'h0000);
      // Read enable released on the very edge that sees deselect
      u_pscfg_host_model.drive(1, 1, 1, 1, 2'b11, 22'h000020, 16'h0000);
      stby_wait(n1);
      // One more cycle for the flop behind the standby timer
      chk(n1 - n0, READ_CYC + 1);
      $display("standby test done");
   endtask

   task automatic t_async_write;
      u_pscfg_host_model.drive(0, 0, 1, 1, 2'b11, 22'h000040, 16'h0000);
      u_pscfg_host_model.drive(0, 1, 1, 0, 2'b01, 22'h000040, 16'hc3c3);
      // Select closes the write while write enable is still low
      u_pscfg_host_model.drive(1, 1, 1, 0, 2'b01, 22'h000040, 16'hc3c3);
      u_pscfg_host_model.drive(1, 1, 1, 1, 2'b11, 22'h000000, 16'h0000);
      chk({wr_r.valid, wr_r.byte_en, wr_r.addr}, {3'h6, 22'h000040});
      chk(wr_r.data, 16'hc3c3);
      $display("async write test done");
   endtask

   task automatic t_power;
      u_pscfg_host_model.power(1'b0);
      repeat (2) tick();
      chk({powered_down_r, sync_mode_r}, 2'h2);
      chk(cfg_key_r, KEY_RESET);
      u_pscfg_host_model.power(1'b1);
      repeat (2) tick();
      chk(powered_down_r, 1'b0);
      $display("power-down test done");
   endtask

   initial begin
      rst_n = 1'b0;
      repeat (2) @(posedge clock);
      #10;
      rst_n = 1'b1;
      t_abandon();
      t_cfg(22'h3f8abc, READ_CYC, 1'b1);
      t_sync_write();
      t_cfg(22'h3f0011, RECOV_CYC, 1'b0);
      t_standby();
      t_async_write();
      t_cfg(22'h3f8001, READ_CYC, 1'b1);
      t_power();
      stop_test();
   end
endmodule

// >>> verif/pscfg_ctrl_monitor.sv
// Port-level assertions for the pSRAM configuration control
`timescale 1ns/1ps
module pscfg_ctrl_monitor
   import pscfg_pkg::*;
(
   // Clock and reset
   input wire logic              clock,
   input wire logic              rst_n,
   // Observed ports
   input wire pscfg_bus_t        bus,
   input wire pscfg_wr_t         wr_r,
   input wire logic              sync_mode_r,
   input wire logic [DATA_W-1:0] cfg_key_r,
   input wire logic              cfg_busy_r,
   input wire logic              wait_n_r,
   input wire logic              standby_r,
   input wire logic              powered_down_r
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   wait_follow_a: assert property (
      wait_n_r == !cfg_busy_r) else $error("wait disagrees with busy");
   busy_len_a: assert property (
      $rose(cfg_busy_r) |=> cfg_busy_r ##1 !cfg_busy_r)
      else $error("busy length wrong");
   busy_cause_a: assert property (
      $rose(cfg_busy_r) |-> $past(bus.chip_select_n))
      else $error("busy without select rise");
   write_cap_a: assert property (
      sync_mode_r && !cfg_busy_r && bus.power_enable
      && !bus.chip_select_n && !bus.write_enable_n && bus.address_valid_n
      |=> wr_r.valid && wr_r.data == $past(bus.data))
      else $error("sync write not captured");
   pd_reset_a: assert property (
      !bus.power_enable |=> powered_down_r && !sync_mode_r
      && cfg_key_r == KEY_RESET) else $error("power-down reset missing");
   pd_exit_a: assert property (
      $rose(bus.power_enable) |-> ##[1:2] !powered_down_r)
      else $error("power-down not left");
   stby_clear_a: assert property (
      !bus.chip_select_n |=> !standby_r) else $error("standby while selected");
   stby_cause_a: assert property (
      $rose(standby_r) |-> $past(bus.chip_select_n))
      else $error("standby without deselect");
   key_hold_a: assert property (
      $changed(cfg_key_r) |-> cfg_busy_r || !$past(bus.power_enable))
      else $error("key changed outside a sequence");

   cover property ($rose(cfg_busy_r));
   cover property (wr_r.valid);
   cover property ($rose(powered_down_r));
   cover property ($rose(standby_r));
endmodule

bind pscfg_ctrl pscfg_ctrl_monitor u_pscfg_ctrl_monitor (
   .clock(clock), .rst_n(rst_n), .bus(bus), .wr_r(wr_r),
   .sync_mode_r(sync_mode_r), .cfg_key_r(cfg_key_r),
   .cfg_busy_r(cfg_busy_r), .wait_n_r(wait_n_r),
   .standby_r(standby_r), .powered_down_r(powered_down_r));

// >>> verif/pscfg_host_model.sv
// Host memory controller model driving the pSRAM parallel bus
`timescale 1ns/1ps
module pscfg_host_model
   import pscfg_pkg::*;
(
   // Clock
   input  wire logic clock,
   // Bus toward the device
   output pscfg_bus_t bus
);
   initial bus = {7'h7f, {(ADDR_W + DATA_W){1'b0}}};

   // One bus state per clock, set just after the rising edge
   task automatic drive(input logic cs_n, adv_n, oe_n, we_n,
                        input logic [1:0] be_n,
                        input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
      @(posedge clock);
      #10;
      bus.chip_select_n   = cs_n;
      bus.address_valid_n = adv_n;
      bus.output_enable_n = oe_n;
      bus.write_enable_n  = we_n;
      {bus.high_byte_enable_n, bus.low_byte_enable_n} = be_n;
      // Released lines toggle so a stale value is never mistaken for live
      bus.addr = adv_n ? ~bus.addr : a;
      bus.data = we_n ? ~bus.data : d;
   endtask

   task automatic cfg_access(input logic [ADDR_W-1:0] a,
                             input logic [1:0]        be_n);
      drive(1'b0, 1'b0, 1'b1, 1'b1, be_n, a, a[DATA_W-1:0]);
      drive(1'b1, 1'b1, 1'b1, 1'b1, 2'b11, a, a[DATA_W-1:0]);
   endtask

   task automatic power(input logic on);
      @(posedge clock);
      #10;
      bus.power_enable = on;
   endtask
endmodule
